// File: design/frc_pkg.sv
// package of constants for the fixed voltage reference control register block
// assumes a 32-bit classic wishbone slave view; register is one aligned word
package frc_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] FRC_CTRL_OFFSET = 8'h00;
   localparam logic [7:0] FRC_CTRL_RESET = 8'h00;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int FRC_REF_EN_BIT = 7;
   localparam int FRC_REF_RDY_BIT = 6;
   localparam int FRC_TS_EN_BIT = 5;
   localparam int FRC_TS_RNG_BIT = 4;
   localparam int FRC_CMP_GAIN_LSB = 2;
   localparam int FRC_ADC_GAIN_LSB = 0;
   // ----------------------------------------
   // settle time of the reference before ready
   // ----------------------------------------
   localparam int FRC_SETTLE_NS = 25000;
   localparam int FRC_CLK_NS = 25;
   localparam int FRC_SETTLE_CYC = (FRC_SETTLE_NS + FRC_CLK_NS - 1) / FRC_CLK_NS;
   // ----------------------------------------
   // gain selections, one-hot
   // ----------------------------------------
   typedef enum logic [3:0] {
      FRC_GAIN_OFF = 4'h1,
      FRC_GAIN_1X = 4'h2,
      FRC_GAIN_2X = 4'h4,
      FRC_GAIN_4X = 4'h8
   } frc_gain_t;
endpackage : frc_pkg

// File: design/frc_gain_decode.sv
// decodes a two-bit gain code into a one-hot gain selection
// assumes the caller states whether code 00 means off or 1x
`timescale 1ns/1ps
`default_nettype none
module frc_gain_decode
   import frc_pkg::*;
(
   input wire logic [1:0] code_i,
   input wire logic has_off_i,
   output frc_pkg::frc_gain_t gain_o
);
   import frc_pkg::*;

   always_comb begin
      case (code_i)
         2'h3: gain_o = FRC_GAIN_4X;
         2'h2: gain_o = FRC_GAIN_2X;
         2'h1: gain_o = FRC_GAIN_1X;
         default: gain_o = has_off_i ? FRC_GAIN_OFF : FRC_GAIN_1X;
      endcase
   end
endmodule : frc_gain_decode
`default_nettype wire

// File: design/frc_settle_timer.sv
// counts the reference settle time after enable and raises ready
// assumes a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module frc_settle_timer
   import frc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic enable_i,
   output logic ready_o
);
   import frc_pkg::*;

   logic [15:0] count_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i || !enable_i) begin
         count_reg <= 16'h0000;
         ready_o <= 1'b0;
      end else if (count_reg == 16'(FRC_SETTLE_CYC - 1)) begin
         ready_o <= 1'b1;
      end else begin
         count_reg <= count_reg + 16'h0001;
      end
   end
endmodule : frc_settle_timer
`default_nettype wire

// File: design/frc_ctrl.sv
// control and status register for the fixed voltage reference and temp sensor
// assumes a classic wishbone master on the system clock, 32-bit data
`timescale 1ns/1ps
`default_nettype none
module frc_ctrl
   import frc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   output logic ref_enable_o,
   output logic ref_ready_o,
   output logic sensor_power_o,
   output logic range_high_o,
   output frc_pkg::frc_gain_t cmp_gain_o,
   output frc_pkg::frc_gain_t adc_gain_o,
   output logic adc_temp_route_o
);
   import frc_pkg::*;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic req;
   logic hit;
   logic wr_en;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign hit = wb_adr_i == FRC_CTRL_OFFSET;
   assign wr_en = req && hit && wb_we_i && wb_sel_i[0];

   // ----------------------------------------
   // control register
   // ----------------------------------------
   logic [7:0] ctrl_reg;
   logic ready;
   frc_gain_t cmp_gain;
   frc_gain_t adc_gain;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_reg <= FRC_CTRL_RESET;
      end else if (wr_en) begin
         ctrl_reg <= wb_dat_i[7:0] & ~(8'h01 << FRC_REF_RDY_BIT);
      end
   end

   frc_settle_timer u_settle (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .enable_i(ctrl_reg[FRC_REF_EN_BIT]),
      .ready_o(ready)
   );

   frc_gain_decode u_cmp_dec (
      .code_i(ctrl_reg[FRC_CMP_GAIN_LSB +: 2]),
      .has_off_i(1'b0),
      .gain_o(cmp_gain)
   );

   // adc path off on code 00
   frc_gain_decode u_adc_dec (
      .code_i(ctrl_reg[FRC_ADC_GAIN_LSB +: 2]),
      .has_off_i(1'b1),
      .gain_o(adc_gain)
   );

   // ----------------------------------------
   // bus answer, one cycle after request
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req && hit;
         wb_err_o <= req && !hit;
         if (req && hit && !wb_we_i) begin
            wb_dat_o <= {24'h00_0000, ctrl_reg[7], ready, ctrl_reg[5:0]};
         end else begin
            wb_dat_o <= 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------
   // analog controls, registered
   // ----------------------------------------
   // one register per control (four flops for each one-hot gain), so every output leaves a register of its own

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_enable_o <= 1'b0;
      end else begin
         ref_enable_o <= ctrl_reg[FRC_REF_EN_BIT];
      end
   end

   // ready status
   // lags the timer by one cycle, so it falls one cycle after the enable output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_ready_o <= 1'b0;
      end else begin
         ref_ready_o <= ready;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sensor_power_o <= 1'b0;
      end else begin
         sensor_power_o <= ctrl_reg[FRC_TS_EN_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         range_high_o <= 1'b0;
      end else begin
         range_high_o <= ctrl_reg[FRC_TS_RNG_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmp_gain_o <= FRC_GAIN_1X;
      end else begin
         cmp_gain_o <= cmp_gain;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         adc_gain_o <= FRC_GAIN_OFF;
      end else begin
         adc_gain_o <= adc_gain;
      end
   end

   // internal route to adc mux
   // follows the sensor enable, so a powered-down sensor is never offered to the adc
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         adc_temp_route_o <= 1'b0;
      end else begin
         adc_temp_route_o <= ctrl_reg[FRC_TS_EN_BIT];
      end
   end

   // ----------------------------------------
   // settle watch, read only by the checks
   // ----------------------------------------
   logic [15:0] en_cycles_reg;
   // own count, so a timer off by one is caught
   always_ff @(posedge clk_i) begin
      if (rst_i || !ctrl_reg[FRC_REF_EN_BIT]) begin
         en_cycles_reg <= 16'h0000;
      end else if (en_cycles_reg != 16'(FRC_SETTLE_CYC)) begin
         en_cycles_reg <= en_cycles_reg + 16'h0001;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // sampled at the rising edge; reset switches every assertion off, the covers have no disable

   a_ready_masked: assert property (@(posedge clk_i) disable iff (rst_i)
      !ctrl_reg[FRC_REF_RDY_BIT])
      else $error("ready bit stored");
   a_write_fields: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_en |=> ctrl_reg == ($past(wb_dat_i[7:0]) & 8'hbf))
      else $error("write lost");
   a_sel_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      req && hit && wb_we_i && !wb_sel_i[0] |=> $stable(ctrl_reg))
      else $error("write without lane");
   a_err_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
      req && !hit |=> wb_err_o && !wb_ack_o && $stable(ctrl_reg))
      else $error("unmapped access wrong");
   a_write_ack: assert property (@(posedge clk_i) disable iff (rst_i)
      req && hit && wb_we_i |=> wb_ack_o && !wb_err_o)
      else $error("write not acked");

   a_read_lanes: assert property (@(posedge clk_i) disable iff (rst_i)
      req && hit && !wb_we_i |=> wb_ack_o && wb_dat_o[31:8] == 24'h00_0000)
      else $error("read lanes wrong");
   a_read_ready: assert property (@(posedge clk_i) disable iff (rst_i)
      req && hit && !wb_we_i |=> wb_dat_o[FRC_REF_RDY_BIT] == $past(ready))
      else $error("ready read wrong");
   a_dat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("data without ack");
   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   a_err_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_err_o |=> !wb_err_o)
      else $error("err held");
   a_ack_err_excl: assert property (@(posedge clk_i) disable iff (rst_i)
      !(wb_ack_o && wb_err_o))
      else $error("ack and err together");

   a_enable_out: assert property (@(posedge clk_i) disable iff (rst_i)
      ref_enable_o == $past(ctrl_reg[FRC_REF_EN_BIT]))
      else $error("enable wrong");
   a_ready_early: assert property (@(posedge clk_i) disable iff (rst_i)
      ready |-> en_cycles_reg == 16'(FRC_SETTLE_CYC))
      else $error("ready too early");
   a_ready_settle: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_reg[FRC_REF_EN_BIT] && en_cycles_reg == 16'(FRC_SETTLE_CYC) |=> ready)
      else $error("ready too late");
   a_ready_drop: assert property (@(posedge clk_i) disable iff (rst_i)
      !ctrl_reg[FRC_REF_EN_BIT] |=> !ready)
      else $error("ready while disabled");

   a_range_out: assert property (@(posedge clk_i) disable iff (rst_i)
      range_high_o == $past(ctrl_reg[FRC_TS_RNG_BIT]))
      else $error("range wrong");
   a_cmp_no_off: assert property (@(posedge clk_i) disable iff (rst_i)
      cmp_gain_o != FRC_GAIN_OFF)
      else $error("cmp gain off");
   a_cmp_code: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_reg[FRC_CMP_GAIN_LSB +: 2] == 2'h3 |=> cmp_gain_o == FRC_GAIN_4X)
      else $error("cmp gain wrong");
   a_cmp_2x: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_reg[FRC_CMP_GAIN_LSB +: 2] == 2'h2 |=> cmp_gain_o == FRC_GAIN_2X)
      else $error("cmp gain not 2x");
   a_cmp_low: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_reg[FRC_CMP_GAIN_LSB + 1] == 1'b0 |=> cmp_gain_o == FRC_GAIN_1X)
      else $error("cmp gain not 1x");

   a_adc_off: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_reg[FRC_ADC_GAIN_LSB +: 2] == 2'h0 |=> adc_gain_o == FRC_GAIN_OFF)
      else $error("adc not off");
   a_adc_1x: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_reg[FRC_ADC_GAIN_LSB +: 2] == 2'h1 |=> adc_gain_o == FRC_GAIN_1X)
      else $error("adc gain not 1x");
   a_adc_2x: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_reg[FRC_ADC_GAIN_LSB +: 2] == 2'h2 |=> adc_gain_o == FRC_GAIN_2X)
      else $error("adc gain not 2x");
   a_adc_4x: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_reg[FRC_ADC_GAIN_LSB +: 2] == 2'h3 |=> adc_gain_o == FRC_GAIN_4X)
      else $error("adc gain not 4x");

   a_temp_route: assert property (@(posedge clk_i) disable iff (rst_i)
      adc_temp_route_o == $past(ctrl_reg[FRC_TS_EN_BIT]))
      else $error("route mismatch");
   a_sensor_power: assert property (@(posedge clk_i) disable iff (rst_i)
      !ctrl_reg[FRC_TS_EN_BIT] |=> !sensor_power_o)
      else $error("sensor powered");
   a_sensor_on: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_reg[FRC_TS_EN_BIT] |=> sensor_power_o)
      else $error("sensor not powered");

   c_write: cover property (@(posedge clk_i) wr_en);
   c_read: cover property (@(posedge clk_i) req && hit && !wb_we_i);
   c_error: cover property (@(posedge clk_i) wb_err_o);
   c_ready: cover property (@(posedge clk_i) $rose(ref_ready_o));
   c_adc_off: cover property (@(posedge clk_i) adc_gain_o == FRC_GAIN_OFF && ref_enable_o);
endmodule : frc_ctrl
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the reference control register
// assumes frc_pkg and the design modules are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
   import frc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, seed = 32'h2449ee8c;
   logic wb_ack_o, wb_err_o, e, ref_enable_o, ref_ready_o, sensor_power_o;
   logic range_high_o, adc_temp_route_o;
   logic [7:0] v;
   frc_gain_t cmp_gain_o, adc_gain_o;
   int errors = 0, comparisons = 0, cycles = 0;
   frc_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .ref_enable_o(ref_enable_o), .ref_ready_o(ref_ready_o),
      .sensor_power_o(sensor_power_o), .range_high_o(range_high_o),
      .cmp_gain_o(cmp_gain_o), .adc_gain_o(adc_gain_o), .adc_temp_route_o(adc_temp_route_o));
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   // ceiling well above the ~1140 cycles the run needs
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         report_and_stop();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         errors++;
         $display("Error %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
   endfunction : xs
   // one-hot gain; only the adc path has an off code
   function automatic logic [3:0] gain(input logic [1:0] c, input logic off);
      gain = (c == 2'b00 && !off) ? 4'h2 : 4'h1 << c;
   endfunction : gain
   // ack is taken right after the rising edge, before the slave's flops move
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
      chk("latency", n, 2);
      q = wb_dat_o;
      e = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   task automatic outs(input logic [7:0] r);
      @(negedge clk_i);
      chk("ref_enable", ref_enable_o, r[7]);
      chk("ref_ready", ref_ready_o, r[6]);
      chk("sensor_power", sensor_power_o, r[5]);
      chk("temp_route", adc_temp_route_o, r[5]);
      chk("range_high", range_high_o, r[4]);
      chk("cmp_gain", cmp_gain_o, gain(r[3:2], 1'b0));
      chk("adc_gain", adc_gain_o, gain(r[1:0], 1'b1));
      wb(1'b0, FRC_CTRL_OFFSET, 4'hf, 32'h0);
      chk("read", q, {24'h0, r});
   endtask : outs
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      outs(FRC_CTRL_RESET);
      // every gain code of both fields, ready bit written at random
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         v = {1'b0, seed[6:4], 4'(i)};
         wb(1'b1, FRC_CTRL_OFFSET, 4'h1, {seed[31:8], v});
         outs(v & 8'hbf);
      end
      v = v & 8'hbf;
      wb(1'b1, FRC_CTRL_OFFSET, 4'he, 32'hff);
      outs(v);
      wb(1'b1, 8'h04, 4'hf, 32'hff);
      chk("unmapped_err", e, 1'b1);
      outs(v);
      wb(1'b1, FRC_CTRL_OFFSET, 4'h1, 32'hb5);
      repeat (985) @(posedge clk_i);
      outs(8'hb5);
      for (int k = 0; k < 40 && ref_ready_o !== 1'b1; k++) @(posedge clk_i);
      outs(8'hf5);
      wb(1'b1, FRC_CTRL_OFFSET, 4'h1, 32'h75);
      // the ready output trails the enable output by one cycle on the way down
      @(posedge clk_i);
      outs(8'h35);
      // reset in mid-run must bring every output back to its reset level
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      outs(FRC_CTRL_RESET);
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
